// [hw/int_ctrl.v]
// How it works
// - Every source owns a hardware-set request flag and a software enable.
// - Control registers hold enable bits and request flags side by side.
// - Bit names: source, optional number, then enable or flag suffix.
// - Four group registers fold secondary sources into four group requests.
// - Edge select register sets trigger type for both pins, two bits each.
// - Pin B field bits 3..2: off, rising, falling, both edges.
// - Pin A field bits 1..0: off, rising, falling, both edges.
// - Edge select bits 7..4 read zero.
// - Pin requests come from detected pin edges; others are internal.
// - Primary 0: touch flag bit 6, touch enable bit 3, reset zero.
// - Primary 0: pin B flag bit 5, pin A flag bit 4, reset zero.
// - Primary 0: pin A enable bit 1, pin B bit 2, global bit 0.
// - Low supply request is a group 3 member and also pollable.
// - Low supply flag sets only after status held high for a delay.
// - Setting of the low supply flag raises a wake request.
// - Status reads high while supply is below the chosen threshold.
// - Detector runs in power-down while enabled; reference auto-on.
// - Status may toggle near threshold; flag logic tolerates it.
// - Detector enable 1 on, 0 off; status read-only, resets 0.
`include "int_ctrl_consts.vh"
`default_nettype none

module int_ctrl (
  input  wire        sys_clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg  [1:0]  response,
  // External pins
  input  wire        ext_int_pin_a,
  input  wire        ext_int_pin_b,
  // Internal event pulses
  input  wire        touch_evt,
  input  wire        uart_evt,
  input  wire        adc_evt,
  input  wire [1:0]  timebase_evt,
  input  wire [1:0]  mfg0_evt,
  input  wire [3:0]  mfg1_evt,
  input  wire [2:0]  mfg2_evt,
  input  wire        eeprom_evt,
  // Analog comparator output, high while supply below threshold
  input  wire        low_supply_cmp,
  // To CPU core and power control
  output reg  [9:0]  cpu_irq_ff,
  output reg         wake_ff,
  output reg         low_supply_detector_enable
);

  reg [7:0] edge_sel_ff;
  reg [7:0] pri0_ff;
  reg [7:0] pri1_ff;
  reg [7:0] pri2_ff;
  reg [7:0] mfg0_ff;
  reg [7:0] mfg1_ff;
  reg [7:0] mfg2_ff;
  reg [7:0] mfg3_ff;
  reg       low_supply_status;
  reg [`LV_CNT_W-1:0] lv_cnt_ff;
  reg       lv_armed_ff;
  reg       lv_set;
  reg       ack_ff;

  wire pin_a_hit;
  wire pin_b_hit;
  wire wr_go;
  wire rd_go;
  wire [3:0] idx;
  wire [7:0] wd;
  wire       wr_lane;

  // Pin edge detectors, one per external pin
  edge_detect u_edge_a (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (ext_int_pin_a),
    .mode    (edge_sel_ff[`ES_A_LSB+1:`ES_A_LSB]),
    .hit_ff  (pin_a_hit)
  );

  edge_detect u_edge_b (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (ext_int_pin_b),
    .mode    (edge_sel_ff[`ES_B_LSB+1:`ES_B_LSB]),
    .hit_ff  (pin_b_hit)
  );

  // One wait cycle per access: answer one cycle after the request
  assign wr_go   = write & ~ack_ff;
  assign rd_go   = read & ~ack_ff;
  assign idx     = address[5:2];
  assign wd      = writedata[7:0];
  assign wr_lane = wr_go & byteenable[0];

  // Low supply delay: status must stay high for the whole count
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      low_supply_status <= 1'b0;
      lv_cnt_ff         <= {`LV_CNT_W{1'b0}};
      lv_armed_ff       <= 1'b0;
    end else begin
      // Detector off reads no low supply
      low_supply_status <= low_supply_cmp &
                           low_supply_detector_enable;
      if (!low_supply_status) begin
        // A drop restarts the wait, so threshold chatter is harmless
        lv_cnt_ff   <= {`LV_CNT_W{1'b0}};
        lv_armed_ff <= 1'b1;
      end else if (lv_armed_ff) begin
        if (lv_cnt_ff == `LV_DELAY_CYC - 1) begin
          lv_armed_ff <= 1'b0;
        end else begin
          lv_cnt_ff <= lv_cnt_ff + 1'b1;
        end
      end
    end
  end

  always @* begin
    lv_set = low_supply_status & lv_armed_ff &
             (lv_cnt_ff == `LV_DELAY_CYC - 1);
  end

  // Register file; hardware sets win over a same-cycle software write
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      edge_sel_ff <= `REG_RESET;
      pri0_ff     <= `REG_RESET;
      pri1_ff     <= `REG_RESET;
      pri2_ff     <= `REG_RESET;
      mfg0_ff     <= `REG_RESET;
      mfg1_ff     <= `REG_RESET;
      mfg2_ff     <= `REG_RESET;
      mfg3_ff     <= `REG_RESET;
      low_supply_detector_enable <= 1'b0;
    end else begin
      if (wr_lane) begin
        case (idx)
          `IDX_EDGE_SEL: edge_sel_ff <= wd & `MASK_EDGE_SEL;
          `IDX_PRI0:     pri0_ff     <= wd & `MASK_PRI0;
          `IDX_PRI1:     pri1_ff     <= wd;
          `IDX_PRI2:     pri2_ff     <= wd;
          `IDX_MFG0:     mfg0_ff     <= wd & `MASK_MFG0;
          `IDX_MFG1:     mfg1_ff     <= wd;
          `IDX_MFG2:     mfg2_ff     <= wd & `MASK_MFG2;
          `IDX_MFG3:     mfg3_ff     <= wd & `MASK_MFG3;
          `IDX_LVD_CTRL: low_supply_detector_enable <=
                           wd[`LV_EN_BIT];
          default: ;
        endcase
      end
      // Primary source flags set by hardware events
      if (touch_evt)
        pri0_ff[`P0_TK_FLAG] <= 1'b1;
      if (pin_a_hit)
        pri0_ff[`P0_PA_FLAG] <= 1'b1;
      if (pin_b_hit)
        pri0_ff[`P0_PB_FLAG] <= 1'b1;
      if (uart_evt) begin
        pri1_ff[`P1_UART_FLAG] <= 1'b1;
      end
      if (adc_evt) begin
        pri1_ff[`P1_ADC_FLAG] <= 1'b1;
      end
      if (timebase_evt[0]) begin
        pri2_ff[`P2_TIMEBASE0_FLAG] <= 1'b1;
      end
      if (timebase_evt[1]) begin
        pri2_ff[`P2_TIMEBASE1_FLAG] <= 1'b1;
      end
      // Member flags; an event beats a clearing write in the same cycle
      mfg0_ff[`MFG0_FLAGS] <= (wr_lane && idx == `IDX_MFG0 ?
                               wd[`MFG0_FLAGS] : mfg0_ff[`MFG0_FLAGS])
                              | mfg0_evt;
      mfg1_ff[`MFG1_FLAGS] <= (wr_lane && idx == `IDX_MFG1 ?
                               wd[`MFG1_FLAGS] : mfg1_ff[`MFG1_FLAGS])
                              | mfg1_evt;
      mfg2_ff[`MFG2_FLAGS] <= (wr_lane && idx == `IDX_MFG2 ?
                               wd[`MFG2_FLAGS] : mfg2_ff[`MFG2_FLAGS])
                              | mfg2_evt;
      if (eeprom_evt) begin
        mfg3_ff[`MFG3_EE_FLAG] <= 1'b1;
      end
      if (lv_set) begin
        mfg3_ff[`MFG3_LV_FLAG] <= 1'b1;
      end
      // Group flags set on a hardware event of any enabled member
      if (|(mfg0_evt & mfg0_ff[`MFG0_ENS])) begin
        pri1_ff[`P1_GRP0_FLAG] <= 1'b1;
      end
      if (|(mfg1_evt & mfg1_ff[`MFG1_ENS])) begin
        pri1_ff[`P1_GRP1_FLAG] <= 1'b1;
      end
      if (|(mfg2_evt & mfg2_ff[`MFG2_ENS])) begin
        pri2_ff[`P2_GRP2_FLAG] <= 1'b1;
      end
      if ((eeprom_evt & mfg3_ff[`MFG3_EE_EN]) |
          (lv_set & mfg3_ff[`MFG3_LV_EN])) begin
        pri2_ff[`P2_GRP3_FLAG] <= 1'b1;
      end
    end
  end

  // CPU request lines: flag and enable, all gated by the global enable
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_irq_ff <= `IRQ_NONE;
      wake_ff    <= 1'b0;
    end else begin
      cpu_irq_ff[`IRQ_PIN_A] <= pri0_ff[`P0_GIE] &
                                pri0_ff[`P0_PA_FLAG] &
                                pri0_ff[`P0_PA_EN];
      cpu_irq_ff[`IRQ_PIN_B] <= pri0_ff[`P0_GIE] &
                                pri0_ff[`P0_PB_FLAG] &
                                pri0_ff[`P0_PB_EN];
      cpu_irq_ff[`IRQ_TOUCH] <= pri0_ff[`P0_GIE] &
                                pri0_ff[`P0_TK_FLAG] &
                                pri0_ff[`P0_TK_EN];
      cpu_irq_ff[`IRQ_UART] <= pri0_ff[`P0_GIE] &
                               pri1_ff[`P1_UART_FLAG] &
                               pri1_ff[`P1_UART_EN];
      cpu_irq_ff[`IRQ_GRP0] <= pri0_ff[`P0_GIE] &
                               pri1_ff[`P1_GRP0_FLAG] &
                               pri1_ff[`P1_GRP0_EN];
      cpu_irq_ff[`IRQ_GRP1] <= pri0_ff[`P0_GIE] &
                               pri1_ff[`P1_GRP1_FLAG] &
                               pri1_ff[`P1_GRP1_EN];
      cpu_irq_ff[`IRQ_ADC] <= pri0_ff[`P0_GIE] &
                              pri1_ff[`P1_ADC_FLAG] &
                              pri1_ff[`P1_ADC_EN];
      cpu_irq_ff[`IRQ_GRP2] <= pri0_ff[`P0_GIE] &
                               pri2_ff[`P2_GRP2_FLAG] &
                               pri2_ff[`P2_GRP2_EN];
      // Both time bases share one line toward the core
      cpu_irq_ff[`IRQ_TIMEBASE] <= pri0_ff[`P0_GIE] &
                                   ((pri2_ff[`P2_TIMEBASE0_FLAG] &
                                     pri2_ff[`P2_TIMEBASE0_EN]) |
                                    (pri2_ff[`P2_TIMEBASE1_FLAG] &
                                     pri2_ff[`P2_TIMEBASE1_EN]));
      cpu_irq_ff[`IRQ_GRP3] <= pri0_ff[`P0_GIE] &
                               pri2_ff[`P2_GRP3_FLAG] &
                               pri2_ff[`P2_GRP3_EN];
      // Wake pulses when the low supply flag sets; a flag already high
      // before sleep hides the event
      wake_ff <= lv_set & ~mfg3_ff[`MFG3_LV_FLAG];
    end
  end

  // Avalon answer: one wait state, then readdata and ack for a cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_ff      <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      response    <= `RESP_OKAY;
    end else begin
      ack_ff      <= (read | write) & ~ack_ff;
      waitrequest <= ~((read | write) & ~ack_ff);
      response    <= `RESP_OKAY;
      if (rd_go) begin
        case (idx)
          `IDX_EDGE_SEL: readdata <= {24'h000000, edge_sel_ff};
          `IDX_PRI0:     readdata <= {24'h000000, pri0_ff};
          `IDX_PRI1:     readdata <= {24'h000000, pri1_ff};
          `IDX_PRI2:     readdata <= {24'h000000, pri2_ff};
          `IDX_MFG0:     readdata <= {24'h000000, mfg0_ff};
          `IDX_MFG1:     readdata <= {24'h000000, mfg1_ff};
          `IDX_MFG2:     readdata <= {24'h000000, mfg2_ff};
          `IDX_MFG3:     readdata <= {24'h000000, mfg3_ff};
          `IDX_LVD_CTRL: readdata <= {26'h0, low_supply_status,
                                      low_supply_detector_enable,
                                      4'h0};
          `IDX_IRQ_STATUS: readdata <= {22'h0, cpu_irq_ff};
          default: begin
            readdata <= 32'h00000000;
            response <= `RESP_SLVERR;                       // Unmapped place
          end
        endcase
      end else if (wr_go) begin
        readdata <= 32'h00000000;
        if (idx > `IDX_IRQ_STATUS) begin
          response <= `RESP_SLVERR;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [hw/int_ctrl_consts.vh]
`ifndef INT_CTRL_CONSTS_VH
`define INT_CTRL_CONSTS_VH

// Register indices, byte address is four times the index
`define IDX_EDGE_SEL    4'h0
`define IDX_PRI0        4'h1
`define IDX_PRI1        4'h2
`define IDX_PRI2        4'h3
`define IDX_MFG0        4'h4
`define IDX_MFG1        4'h5
`define IDX_MFG2        4'h6
`define IDX_MFG3        4'h7
`define IDX_LVD_CTRL    4'h8
`define IDX_IRQ_STATUS  4'h9

// Writable bit masks of the registers that are not fully writable
`define MASK_EDGE_SEL   8'h0F
`define MASK_PRI0       8'h7F
`define MASK_MFG0       8'h33
`define MASK_MFG2       8'h77
`define MASK_MFG3       8'h33
`define MASK_LVD_CTRL   8'h10
`define REG_RESET       8'h00

// Primary register 0 fields
`define P0_GIE          0
`define P0_PA_EN        1
`define P0_PB_EN        2
`define P0_TK_EN        3
`define P0_PA_FLAG      4
`define P0_PB_FLAG      5
`define P0_TK_FLAG      6

// Edge select fields and codes
`define ES_A_LSB        0
`define ES_B_LSB        2
`define EDGE_OFF        2'h0
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`define EDGE_BOTH       2'h3

// Low supply control fields
`define LV_EN_BIT       4
`define LV_STAT_BIT     5

// Group register 3 field for the low supply source
`define MFG3_LV_EN      0
`define MFG3_LV_FLAG    4

// Primary register 1 fields
`define P1_UART_EN      0
`define P1_GRP0_EN      1
`define P1_GRP1_EN      2
`define P1_ADC_EN       3
`define P1_UART_FLAG    4
`define P1_GRP0_FLAG    5
`define P1_GRP1_FLAG    6
`define P1_ADC_FLAG     7

// Primary register 2 fields
`define P2_GRP2_EN      0
`define P2_TIMEBASE0_EN 1
`define P2_TIMEBASE1_EN 2
`define P2_GRP3_EN      3
`define P2_GRP2_FLAG    4
`define P2_TIMEBASE0_FLAG 5
`define P2_TIMEBASE1_FLAG 6
`define P2_GRP3_FLAG    7

// Group member fields: enables in the low nibble, flags in the high one
`define MFG0_ENS        1:0
`define MFG0_FLAGS      5:4
`define MFG1_ENS        3:0
`define MFG1_FLAGS      7:4
`define MFG2_ENS        2:0
`define MFG2_FLAGS      6:4
`define MFG3_EE_EN      1
`define MFG3_EE_FLAG    5

// Request lines toward the core
`define IRQ_NONE        10'h0
`define IRQ_PIN_A       0
`define IRQ_PIN_B       1
`define IRQ_TOUCH       2
`define IRQ_UART        3
`define IRQ_GRP0        4
`define IRQ_GRP1        5
`define IRQ_ADC         6
`define IRQ_GRP2        7
`define IRQ_TIMEBASE    8
`define IRQ_GRP3        9

// Avalon response codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Low supply request delay
`define LV_DELAY_NS     32'd10000
`define CLK_PERIOD_NS   32'd10
`define LV_DELAY_CYC    (`LV_DELAY_NS / `CLK_PERIOD_NS)
`define LV_CNT_W        10

`endif

// [hw/edge_detect.v]
`include "int_ctrl_consts.vh"
`default_nettype none

// Detects the selected edge type on one external pin
module edge_detect (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       pin,
  input  wire [1:0] mode,
  output reg        hit_ff
);

  reg prev_ff;

  // Previous level is reset low, so a pin high at reset looks like a rise
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
      hit_ff  <= 1'b0;
    end else begin
      prev_ff <= pin;
      case (mode)
        `EDGE_RISE: hit_ff <= pin & ~prev_ff;
        `EDGE_FALL: hit_ff <= ~pin & prev_ff;
        `EDGE_BOTH: hit_ff <= pin ^ prev_ff;
        default:    hit_ff <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// [testbench/int_ctrl_chk.sv]
`include "int_ctrl_consts.vh"
`default_nettype none
module int_ctrl_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        low_supply_cmp,
  input wire logic        wake_ff,
  input wire logic        low_supply_detector_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] run_ff;
  // Length of the current low supply spell; saturates so it never wraps
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !(low_supply_cmp && low_supply_detector_enable))
      run_ff <= 11'h000;
    else if (run_ff != 11'h7FF)
      run_ff <= run_ff + 11'h001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_one_cycle: assert property (
    !waitrequest |=> waitrequest) else $error("answer longer than a cycle");
  chk_req_answered: assert property (
    (read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("request not answered");
  chk_bad_index: assert property (
    !waitrequest && (read || write) && address[5:2] > 4'h9
    |-> response == 2'h2) else $error("unmapped place answered OK");
  chk_read_upper: assert property (
    !waitrequest && read |-> readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_edge_hi_zero: assert property (
    !waitrequest && read && address[5:2] == `IDX_EDGE_SEL
    |-> readdata[7:4] == 4'h0) else $error("edge select top bits set");
  chk_wake_pulse: assert property (
    wake_ff |=> !wake_ff) else $error("wake pulse too long");
  chk_wake_delay: assert property (
    wake_ff |-> run_ff >= 11'd1000) else $error("wake before delay");
  chk_lv_enable: assert property (
    write && !waitrequest && byteenable[0]
    && address[5:2] == `IDX_LVD_CTRL
    |=> low_supply_detector_enable == $past(writedata[`LV_EN_BIT]))
    else $error("detector enable not taken");
endmodule
bind int_ctrl int_ctrl_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .response(response), .low_supply_cmp(low_supply_cmp), .wake_ff(wake_ff),
  .low_supply_detector_enable(low_supply_detector_enable));
`default_nettype wire

// [testbench/src_model.sv]
`default_nettype none
// Event sources, pins and supply comparator around the controller
module src_model (
  input  wire logic        sys_clk,
  input  wire logic        wake_ff,
  output var  logic        pin_a,
  output var  logic        pin_b,
  output var  logic [14:0] evt,
  output var  logic        cmp,
  output var  int          wakes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    evt = 15'h0;
    cmp = 1'b0;
    wakes = 0;
  end
  // Wake pulses are counted, the core would leave sleep on each
  always @(posedge sys_clk) begin
    if (wake_ff === 1'b1)
      wakes <= wakes + 1;
  end
  task automatic set_pin(input int p, input logic lvl);
    @(posedge sys_clk);
    if (p == 0)
      pin_a <= lvl;
    else
      pin_b <= lvl;
  endtask
  // Peripherals signal with one-cycle pulses
  task automatic pulse(input int b);
    @(posedge sys_clk);
    evt[b] <= 1'b1;
    @(posedge sys_clk);
    evt <= 15'h0;
  endtask
  // Supply may dip and recover at any edge near the threshold
  task automatic set_cmp(input logic lvl);
    @(posedge sys_clk);
    cmp <= lvl;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`include "int_ctrl_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic        pin_a, pin_b, cmp, wake, lv_en;
  logic [14:0] evt;
  logic [9:0]  irq;
  logic [7:0]  rd;
  logic [1:0]  rsp;
  int          wakes;
  int          err_total = 0;
  int          compares = 0;
  always #5 sys_clk = ~sys_clk;
  int_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response),
    .ext_int_pin_a(pin_a), .ext_int_pin_b(pin_b), .touch_evt(evt[0]),
    .uart_evt(evt[1]), .adc_evt(evt[2]), .timebase_evt(evt[4:3]),
    .mfg0_evt(evt[6:5]), .mfg1_evt(evt[10:7]), .mfg2_evt(evt[13:11]),
    .eeprom_evt(evt[14]), .low_supply_cmp(cmp), .cpu_irq_ff(irq),
    .wake_ff(wake), .low_supply_detector_enable(lv_en));
  src_model i_src (.sys_clk(sys_clk), .wake_ff(wake), .pin_a(pin_a),
    .pin_b(pin_b), .evt(evt), .cmp(cmp), .wakes(wakes));
  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request stays up until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [3:0] idx,
                      input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    address <= {idx, 2'h0};
    read <= !w;
    write <= w;
    writedata <= {24'h000000, d};
    byteenable <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      err_total++;
      $display("FAIL %0t no answer on the register bus", $time);
      tally_and_finish;
    end else begin
      rd = readdata[7:0];
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 4'h1);
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, 4'hF);
    chk_val({22'h0, rsp, rd}, {24'h000000, exp});
  endtask
  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rd_chk(4'(i), 8'h00);
    xfer(1'b1, 4'hF, 8'hFF, 4'hF);
    chk_val({30'h0, rsp}, 32'h00000002);
    $display("t_reset done");
  endtask
  // Masks, ignored byte lanes and the global gate
  task automatic t_regs;
    wr(`IDX_EDGE_SEL, 8'hFF);
    rd_chk(`IDX_EDGE_SEL, 8'h0F);
    xfer(1'b1, `IDX_PRI0, 8'hFF, 4'h0);
    rd_chk(`IDX_PRI0, 8'h00);
    wr(`IDX_PRI0, 8'hFF);
    repeat (3) @(posedge sys_clk);
    chk_val({22'h0, irq}, 32'h00000007);
    rd_chk(`IDX_PRI0, 8'h7F);
    wr(`IDX_PRI0, 8'h7E);
    repeat (3) @(posedge sys_clk);
    chk_val({22'h0, irq}, 32'h00000000);
    wr(`IDX_LVD_CTRL, 8'hFF);
    rd_chk(`IDX_LVD_CTRL, 8'h10);
    chk_val({31'h0, lv_en}, 32'h00000001);
    wr(`IDX_LVD_CTRL, 8'h00);
    chk_val({31'h0, lv_en}, 32'h00000000);
    $display("t_regs done");
  endtask
  // Every edge mode on each pin, rising then falling
  task automatic t_pins;
    logic [7:0] f;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        f = 8'h10 << p;
        wr(`IDX_PRI0, 8'h00);
        wr(`IDX_EDGE_SEL, 8'(m << (2 * p)));
        i_src.set_pin(p, 1'b1);
        repeat (4) @(posedge sys_clk);
        rd_chk(`IDX_PRI0, m[0] ? f : 8'h00);
        wr(`IDX_PRI0, 8'h00);
        i_src.set_pin(p, 1'b0);
        repeat (4) @(posedge sys_clk);
        rd_chk(`IDX_PRI0, m[1] ? f : 8'h00);
      end
    end
    $display("t_pins done");
  endtask
  // Touch last, since clearing its register drops the global enable
  task automatic t_sources;
    logic [3:0] ri [5] = '{`IDX_PRI1, `IDX_PRI1, `IDX_PRI2, `IDX_PRI2,
                           `IDX_PRI0};
    logic [7:0] en [5] = '{8'h01, 8'h08, 8'h02, 8'h04, 8'h09};
    logic [7:0] fl [5] = '{8'h10, 8'h80, 8'h20, 8'h40, 8'h40};
    int ev [5] = '{1, 2, 3, 4, 0};
    int iq [5] = '{3, 6, 8, 8, 2};
    wr(`IDX_PRI0, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(ri[i], en[i]);
      i_src.pulse(ev[i]);
      repeat (3) @(posedge sys_clk);
      chk_val({22'h0, irq}, 32'h00000001 << iq[i]);
      rd_chk(ri[i], en[i] | fl[i]);
      wr(ri[i], 8'h00);
    end
    $display("t_sources done");
  endtask
  // One member per group: flag alone first, then with its member enable
  task automatic t_groups;
    logic [3:0] gr [4] = '{`IDX_MFG0, `IDX_MFG1, `IDX_MFG2, `IDX_MFG3};
    logic [3:0] pr [4] = '{`IDX_PRI1, `IDX_PRI1, `IDX_PRI2, `IDX_PRI2};
    logic [7:0] me [4] = '{8'h01, 8'h02, 8'h04, 8'h02};
    logic [7:0] mf [4] = '{8'h10, 8'h20, 8'h40, 8'h20};
    logic [7:0] pe [4] = '{8'h02, 8'h04, 8'h01, 8'h08};
    logic [7:0] pf [4] = '{8'h20, 8'h40, 8'h10, 8'h80};
    int ev [4] = '{5, 8, 13, 14};
    int iq [4] = '{4, 5, 7, 9};
    wr(`IDX_PRI0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(pr[i], pe[i]);
      i_src.pulse(ev[i]);
      repeat (3) @(posedge sys_clk);
      rd_chk(gr[i], mf[i]);
      rd_chk(pr[i], pe[i]);
      wr(gr[i], me[i]);
      i_src.pulse(ev[i]);
      repeat (3) @(posedge sys_clk);
      chk_val({22'h0, irq}, 32'h00000001 << iq[i]);
      rd_chk(pr[i], pe[i] | pf[i]);
      wr(gr[i], 8'h00);
      wr(pr[i], 8'h00);
    end
    $display("t_groups done");
  endtask
  task automatic t_low_supply;
    wr(`IDX_PRI0, 8'h01);
    wr(`IDX_PRI2, 8'h08);
    wr(`IDX_MFG3, 8'h01);
    wr(`IDX_LVD_CTRL, 8'h10);
    repeat (20) @(posedge sys_clk); // Settle before trusting status
    i_src.set_cmp(1'b1);
    repeat (500) @(posedge sys_clk);
    i_src.set_cmp(1'b0);
    i_src.set_cmp(1'b1);
    repeat (1100) @(posedge sys_clk);
    chk_val(32'(wakes), 32'h00000001);
    rd_chk(`IDX_LVD_CTRL, 8'h30);
    rd_chk(`IDX_MFG3, 8'h11);
    rd_chk(`IDX_PRI2, 8'h88);
    chk_val({22'h0, irq}, 32'h00000200);
    i_src.set_cmp(1'b0);
    wr(`IDX_MFG3, 8'h11); // Preset flag, no wake wanted
    i_src.set_cmp(1'b1);
    repeat (1100) @(posedge sys_clk);
    chk_val(32'(wakes), 32'h00000001);
    i_src.set_cmp(1'b0);
    $display("t_low_supply done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_pins;
    t_sources;
    t_groups;
    t_low_supply;
    tally_and_finish;
  end
endmodule
`default_nettype wire
